// [rtl/mpic_input_ctrl.v]
`timescale 1ns/1ns
`include "mpic_defines.vh"
module mpic_input_ctrl #(
	parameter PCB_WORDS = `MPIC_PCB_WORDS,
	parameter FIFO_DEPTH = `MPIC_FIFO_DEPTH,
	parameter FIFO_AW = `MPIC_FIFO_AW
) (
	input wire core_clk,
	input wire reset,
	input wire rx_valid,
	output wire rx_ready,
	input wire [6:0] rx_port,
	input wire [7:0] rx_char,
	input wire rx_parity_err,
	input wire rx_overload,
	input wire rx_break,
	input wire rx_special,
	input wire rx_echo_blocked,
	input wire [14:0] pcb_base,
	output reg mem_req_r,
	output reg mem_we_r,
	output reg [14:0] mem_addr_r,
	output reg [15:0] mem_wdata_r,
	input wire mem_ack,
	input wire [15:0] mem_rdata,
	output reg echo_valid_r,
	output reg [6:0] echo_port_r,
	output reg [7:0] echo_char_r,
	input wire rtc_event,
	input wire stack_overflow,
	input wire io_read_status,
	input wire io_read_clear,
	output wire [15:0] io_data,
	output wire io_data_valid,
	output wire host_irq
);
	// ---------------------------------------------------------------
	// Sequencer states
	// ---------------------------------------------------------------
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_RD_ICW = 4'h1;
	localparam [3:0] S_RD_OCW = 4'h2;
	localparam [3:0] S_DECIDE = 4'h3;
	localparam [3:0] S_RD_IBP = 4'h4;
	localparam [3:0] S_RD_LIB = 4'h5;
	localparam [3:0] S_RD_BUF = 4'h6;
	localparam [3:0] S_WR_BUF = 4'h7;
	localparam [3:0] S_WR_IBP = 4'h8;
	localparam [3:0] S_WR_ICW = 4'h9;
	localparam [3:0] S_IRQ = 4'ha;

	localparam [14:0] PCB_W = PCB_WORDS;
	localparam FW = 20;

	reg [3:0] state_r;
	reg [6:0] port_r;
	reg [7:0] char_r;
	reg par_err_r;
	reg overload_r;
	reg break_r;
	reg special_r;
	reg echo_blk_r;
	reg [14:0] blk_r;
	reg [15:0] icw_r;
	reg [15:0] ocw_r;
	reg [15:0] ibp_r;
	reg [15:0] lib_r;
	reg [15:0] buf_r;
	reg full_r;
	reg irq_want_r;
	reg raise_r;

	wire fifo_valid;
	wire fifo_ready;
	wire [FW-1:0] fifo_data;
	wire [FW-1:0] rx_word;
	wire in_pending;
	wire [14:0] port_off;
	wire [1:0] mode;
	wire rx_err;
	wire spec_hit;
	wire echo_fail;
	wire [15:0] buf_merged;

	// ---------------------------------------------------------------
	// Receive event queue
	// ---------------------------------------------------------------
	assign rx_word = {rx_echo_blocked, rx_special, rx_break, rx_overload, rx_parity_err, rx_char, rx_port};

	mpic_fifo #(
		.DW(FW),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.core_clk(core_clk),
		.reset(reset),
		.in_valid(rx_valid),
		.in_ready_r(rx_ready),
		.in_data(rx_word),
		.out_valid_r(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_data)
	);

	assign fifo_ready = (state_r == S_IDLE);

	// ---------------------------------------------------------------
	// Status word and host interrupt
	// ---------------------------------------------------------------
	mpic_status u_status (
		.core_clk(core_clk),
		.reset(reset),
		.raise_in(raise_r),
		.raise_port(port_r),
		.rtc_event(rtc_event),
		.stack_overflow(stack_overflow),
		.io_read_status(io_read_status),
		.io_read_clear(io_read_clear),
		.in_pending_r(in_pending),
		.io_data_r(io_data),
		.io_data_valid_r(io_data_valid),
		.host_irq_r(host_irq)
	);

	// ---------------------------------------------------------------
	// Decode of the fetched control words
	// ---------------------------------------------------------------
	assign port_off = {8'h00, fifo_data[6:0]} * PCB_W;
	assign mode = {icw_r[`MPIC_ICW_MODE_HI], icw_r[`MPIC_ICW_MODE_LO]};
	assign rx_err = (par_err_r & ~ocw_r[`MPIC_OCW_PAR_INH]) | overload_r | break_r;
	assign spec_hit = icw_r[`MPIC_ICW_SPEC_EN] & special_r;
	assign echo_fail = (mode == `MPIC_MODE_ECHO) & echo_blk_r;
	assign buf_merged = ibp_r[`MPIC_PTR_BYTE] ? {buf_r[15:8], char_r} : {char_r, buf_r[7:0]};

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_r <= S_IDLE;
			port_r <= 7'h00;
			char_r <= 8'h00;
			par_err_r <= 1'b0;
			overload_r <= 1'b0;
			break_r <= 1'b0;
			special_r <= 1'b0;
			echo_blk_r <= 1'b0;
			blk_r <= 15'h0000;
			icw_r <= 16'h0000;
			ocw_r <= 16'h0000;
			ibp_r <= 16'h0000;
			lib_r <= 16'h0000;
			buf_r <= 16'h0000;
			full_r <= 1'b0;
			irq_want_r <= 1'b0;
			raise_r <= 1'b0;
			mem_req_r <= 1'b0;
			mem_we_r <= 1'b0;
			mem_addr_r <= 15'h0000;
			mem_wdata_r <= 16'h0000;
			echo_valid_r <= 1'b0;
			echo_port_r <= 7'h00;
			echo_char_r <= 8'h00;
		end else begin
			raise_r <= 1'b0;
			echo_valid_r <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (fifo_valid) begin
						port_r <= fifo_data[6:0];
						char_r <= fifo_data[14:7];
						par_err_r <= fifo_data[15];
						overload_r <= fifo_data[16];
						break_r <= fifo_data[17];
						special_r <= fifo_data[18];
						echo_blk_r <= fifo_data[19];
						blk_r <= pcb_base + port_off;
						full_r <= 1'b0;
						irq_want_r <= 1'b0;
						state_r <= S_RD_ICW;
					end
				end
				S_RD_ICW: begin
					if (!mem_req_r) begin
						mem_req_r <= 1'b1;
						mem_we_r <= 1'b0;
						mem_addr_r <= blk_r + {11'h000, `MPIC_W_ICW};
					end else if (mem_ack) begin
						mem_req_r <= 1'b0;
						icw_r <= mem_rdata;
						state_r <= S_RD_OCW;
					end
				end
				S_RD_OCW: begin
					if (!mem_req_r) begin
						mem_req_r <= 1'b1;
						mem_we_r <= 1'b0;
						mem_addr_r <= blk_r + {11'h000, `MPIC_W_OCW};
					end else if (mem_ack) begin
						mem_req_r <= 1'b0;
						ocw_r <= mem_rdata;
						state_r <= S_DECIDE;
					end
				end
				S_DECIDE: begin
					if (icw_r[`MPIC_ICW_DONE]) begin
						// Done still set: overwrite the held character, no storage, no interrupt.
						icw_r[`MPIC_ICW_CHAR_MSB:`MPIC_ICW_CHAR_LSB] <= char_r;
						icw_r[`MPIC_ICW_LOST] <= 1'b1;
						irq_want_r <= 1'b0;
						state_r <= S_WR_ICW;
					end else if (mode == `MPIC_MODE_SINGLE || mode == `MPIC_MODE_ILLEGAL ||
						rx_err || spec_hit || echo_fail) begin
						icw_r[`MPIC_ICW_CHAR_MSB:`MPIC_ICW_CHAR_LSB] <= char_r;
						icw_r[`MPIC_ICW_DONE] <= 1'b1;
						if (echo_fail) begin
							icw_r[`MPIC_ICW_ECHO_FAIL] <= 1'b1;
						end
						irq_want_r <= 1'b1;
						state_r <= S_WR_ICW;
					end else begin
						state_r <= S_RD_IBP;
					end
				end
				S_RD_IBP: begin
					if (!mem_req_r) begin
						mem_req_r <= 1'b1;
						mem_we_r <= 1'b0;
						mem_addr_r <= blk_r + {11'h000, `MPIC_W_IBP};
					end else if (mem_ack) begin
						mem_req_r <= 1'b0;
						ibp_r <= mem_rdata;
						state_r <= S_RD_LIB;
					end
				end
				S_RD_LIB: begin
					if (!mem_req_r) begin
						mem_req_r <= 1'b1;
						mem_we_r <= 1'b0;
						mem_addr_r <= blk_r + {11'h000, `MPIC_W_LIB};
					end else if (mem_ack) begin
						mem_req_r <= 1'b0;
						lib_r <= mem_rdata;
						state_r <= S_RD_BUF;
					end
				end
				S_RD_BUF: begin
					if (!mem_req_r) begin
						mem_req_r <= 1'b1;
						mem_we_r <= 1'b0;
						mem_addr_r <= ibp_r[`MPIC_PTR_ADDR_MSB:`MPIC_PTR_ADDR_LSB];
					end else if (mem_ack) begin
						mem_req_r <= 1'b0;
						buf_r <= mem_rdata;
						state_r <= S_WR_BUF;
					end
				end
				S_WR_BUF: begin
					if (!mem_req_r) begin
						mem_req_r <= 1'b1;
						mem_we_r <= 1'b1;
						mem_addr_r <= ibp_r[`MPIC_PTR_ADDR_MSB:`MPIC_PTR_ADDR_LSB];
						mem_wdata_r <= buf_merged;
					end else if (mem_ack) begin
						mem_req_r <= 1'b0;
						mem_we_r <= 1'b0;
						full_r <= (ibp_r == lib_r);
						if (mode == `MPIC_MODE_ECHO) begin
							echo_valid_r <= 1'b1;
							echo_port_r <= port_r;
							echo_char_r <= char_r;
						end
						state_r <= S_WR_IBP;
					end
				end
				S_WR_IBP: begin
					if (!mem_req_r) begin
						mem_req_r <= 1'b1;
						mem_we_r <= 1'b1;
						mem_addr_r <= blk_r + {11'h000, `MPIC_W_IBP};
						mem_wdata_r <= ibp_r + 16'h0001;
					end else if (mem_ack) begin
						mem_req_r <= 1'b0;
						mem_we_r <= 1'b0;
						if (full_r) begin
							icw_r[`MPIC_ICW_DONE] <= 1'b1;
							irq_want_r <= 1'b1;
							state_r <= S_WR_ICW;
						end else begin
							state_r <= S_IDLE;
						end
					end
				end
				S_WR_ICW: begin
					if (!mem_req_r) begin
						mem_req_r <= 1'b1;
						mem_we_r <= 1'b1;
						mem_addr_r <= blk_r + {11'h000, `MPIC_W_ICW};
						mem_wdata_r <= icw_r;
					end else if (mem_ack) begin
						mem_req_r <= 1'b0;
						mem_we_r <= 1'b0;
						state_r <= irq_want_r ? S_IRQ : S_IDLE;
					end
				end
				S_IRQ: begin
					// A still-pending input interrupt is served first; the new one waits.
					if (!in_pending && !raise_r) begin
						raise_r <= 1'b1;
						state_r <= S_IDLE;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end
endmodule // mpic_input_ctrl

// [rtl/mpic_defines.vh]
`ifndef MPIC_DEFINES_VH
`define MPIC_DEFINES_VH

// ---------------------------------------------------------------
// Port control block word indices
// ---------------------------------------------------------------
`define MPIC_W_ICW 4'h0
`define MPIC_W_OCW 4'h1
`define MPIC_W_IBP 4'h4
`define MPIC_W_OBP 4'h5
`define MPIC_W_LIB 4'h6
`define MPIC_W_LOB 4'h7
`define MPIC_PCB_WORDS 32

// ---------------------------------------------------------------
// Input control word fields
// ---------------------------------------------------------------
`define MPIC_ICW_DONE 0
`define MPIC_ICW_MODE_HI 1
`define MPIC_ICW_MODE_LO 2
`define MPIC_ICW_SPEC_EN 3
`define MPIC_ICW_ECHO_FAIL 6
`define MPIC_ICW_LOST 7
`define MPIC_ICW_CHAR_LSB 8
`define MPIC_ICW_CHAR_MSB 15

// Mode code is {bit 1, bit 2}.
`define MPIC_MODE_SINGLE 2'h0
`define MPIC_MODE_ILLEGAL 2'h1
`define MPIC_MODE_AUTO 2'h2
`define MPIC_MODE_ECHO 2'h3

// ---------------------------------------------------------------
// Output control word fields
// ---------------------------------------------------------------
`define MPIC_OCW_PAR_INH 8

// ---------------------------------------------------------------
// Byte pointer fields
// ---------------------------------------------------------------
`define MPIC_PTR_BYTE 0
`define MPIC_PTR_ADDR_LSB 1
`define MPIC_PTR_ADDR_MSB 15

// ---------------------------------------------------------------
// Status word fields
// ---------------------------------------------------------------
`define MPIC_ST_RTC 0
`define MPIC_ST_STACK 1
`define MPIC_ST_IN_DONE 2
`define MPIC_ST_OUT_DONE 3
`define MPIC_ST_PORT_LSB 4
`define MPIC_ST_PORT_MSB 10
`define MPIC_ST_RESET 16'h0000

// ---------------------------------------------------------------
// Receive FIFO
// ---------------------------------------------------------------
`define MPIC_FIFO_DEPTH 16
`define MPIC_FIFO_AW 4

`endif

// [rtl/mpic_fifo.v]
`timescale 1ns/1ns
module mpic_fifo #(
	parameter DW = 20,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire core_clk,
	input wire reset,
	input wire in_valid,
	output reg in_ready_r,
	input wire [DW-1:0] in_data,
	output reg out_valid_r,
	input wire out_ready,
	output wire [DW-1:0] out_data
);
	reg [DW-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] cnt_r;
	wire push;
	wire pop;
	wire [AW:0] cnt_nxt;

	assign push = in_valid & in_ready_r;
	assign pop = out_valid_r & out_ready;
	assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_data = mem[rd_ptr_r];

	always @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// ---------------------------------------------------------------
	// Pointers and occupancy
	// ---------------------------------------------------------------
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
			in_ready_r <= 1'b1;
			out_valid_r <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			end
			cnt_r <= cnt_nxt;
			in_ready_r <= (cnt_nxt != DEPTH);
			out_valid_r <= (cnt_nxt != {(AW+1){1'b0}});
		end
	end
endmodule // mpic_fifo

// [rtl/mpic_status.v]
`timescale 1ns/1ns
`include "mpic_defines.vh"
module mpic_status (
	input wire core_clk,
	input wire reset,
	input wire raise_in,
	input wire [6:0] raise_port,
	input wire rtc_event,
	input wire stack_overflow,
	input wire io_read_status,
	input wire io_read_clear,
	output reg in_pending_r,
	output reg [15:0] io_data_r,
	output reg io_data_valid_r,
	output reg host_irq_r
);
	reg [15:0] stat_r;
	reg [15:0] stat_nxt;
	reg [15:0] kept;

	// ---------------------------------------------------------------
	// Status word update; a new event wins over a same-cycle clear.
	// ---------------------------------------------------------------
	always @* begin
		kept = io_read_clear ? `MPIC_ST_RESET : stat_r;
		stat_nxt = kept;
		if (rtc_event) begin
			stat_nxt[`MPIC_ST_RTC] = 1'b1;
		end
		if (stack_overflow) begin
			stat_nxt[`MPIC_ST_STACK] = 1'b1;
		end
		if (raise_in) begin
			stat_nxt[`MPIC_ST_IN_DONE] = 1'b1;
			stat_nxt[`MPIC_ST_PORT_MSB:`MPIC_ST_PORT_LSB] = raise_port;
		end
		stat_nxt[`MPIC_ST_OUT_DONE] = 1'b0;
		stat_nxt[15:11] = 5'h00;
	end

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			stat_r <= `MPIC_ST_RESET;
			in_pending_r <= 1'b0;
			io_data_r <= 16'h0000;
			io_data_valid_r <= 1'b0;
			host_irq_r <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			in_pending_r <= stat_nxt[`MPIC_ST_IN_DONE];
			host_irq_r <= (stat_nxt != 16'h0000);
			io_data_valid_r <= io_read_status | io_read_clear;
			if (io_read_status | io_read_clear) begin
				io_data_r <= stat_r;
			end
		end
	end
endmodule // mpic_status

// [tb/mpic_input_ctrl_sva.sv]
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Port checks
// ---------------------------------------------------------------
module mpic_input_ctrl_sva #(
	parameter PCB_WORDS = 32
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [14:0] pcb_base,
	input wire logic mem_req_r,
	input wire logic mem_we_r,
	input wire logic [14:0] mem_addr_r,
	input wire logic [15:0] mem_wdata_r,
	input wire logic mem_ack,
	input wire logic echo_valid_r,
	input wire logic rtc_event,
	input wire logic stack_overflow,
	input wire logic io_read_status,
	input wire logic io_read_clear,
	input wire logic [15:0] io_data,
	input wire logic io_data_valid,
	input wire logic host_irq
);
	wire [14:0] pcb_off = mem_addr_r - pcb_base;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence read_req_s;
		io_read_status || io_read_clear;
	endsequence
	sequence read_ans_s;
		io_data_valid;
	endsequence
	status_answer_a:
	assert property (read_req_s |=> read_ans_s) else $error("status read not answered");
	answer_cause_a:
	assert property (io_data_valid |-> $past(io_read_status || io_read_clear)) else $error("status answer without read");
	status_zero_a:
	assert property (io_data_valid |-> io_data[15:11] == 5'h00 && !io_data[3]) else $error("status spare bits set");
	event_irq_a:
	assert property ((rtc_event || stack_overflow) |-> ##[1:2] host_irq) else $error("clock or stack event gave no irq");
	status_keep_a:
	assert property (io_data_valid && $past(io_read_status && !io_read_clear) && io_data != 16'h0000 |-> host_irq)
		else $error("plain status read dropped irq");
	mem_hold_a:
	assert property (mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r) && $stable(mem_we_r)
		&& $stable(mem_wdata_r)) else $error("memory request changed before ack");
	req_drop_a:
	assert property (mem_ack |=> !mem_req_r) else $error("memory request held after ack");
	pcb_words_a:
	assert property (mem_req_r && pcb_off < PCB_WORDS * 128 |-> (pcb_off % PCB_WORDS) inside {0, 1, 4, 5, 6, 7})
		else $error("control block word outside the used set");
	echo_pulse_a:
	assert property (echo_valid_r |=> !echo_valid_r) else $error("echo strobe longer than one cycle");
endmodule // mpic_input_ctrl_sva

bind mpic_input_ctrl mpic_input_ctrl_sva #(.PCB_WORDS(PCB_WORDS)) chk (.core_clk(core_clk), .reset(reset),
	.pcb_base(pcb_base), .mem_req_r(mem_req_r), .mem_we_r(mem_we_r), .mem_addr_r(mem_addr_r),
	.mem_wdata_r(mem_wdata_r), .mem_ack(mem_ack), .echo_valid_r(echo_valid_r), .rtc_event(rtc_event),
	.stack_overflow(stack_overflow), .io_read_status(io_read_status), .io_read_clear(io_read_clear),
	.io_data(io_data), .io_data_valid(io_data_valid), .host_irq(host_irq));

// [tb/mpic_mem_model.sv]
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Host memory holding control blocks and buffers
// ---------------------------------------------------------------
module mpic_mem_model (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic mem_req_r,
	input wire logic mem_we_r,
	input wire logic [14:0] mem_addr_r,
	input wire logic [15:0] mem_wdata_r,
	input wire logic stall,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	logic [15:0] ram [0:1023];
	logic [1:0] wait_cnt;
	logic slow;
	// Answers alternate between prompt and slow; idle read data toggles every cycle.
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mem_ack <= 1'b0;
			mem_rdata <= 16'h0000;
			wait_cnt <= 2'h0;
			slow <= 1'b0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req_r && !mem_ack && !stall) begin
				if (wait_cnt == {slow, 1'b0}) begin
					mem_ack <= 1'b1;
					wait_cnt <= 2'h0;
					slow <= ~slow;
					if (mem_we_r)
						ram[mem_addr_r[9:0]] <= mem_wdata_r;
					else
						mem_rdata <= ram[mem_addr_r[9:0]];
				end else begin
					wait_cnt <= wait_cnt + 2'h1;
				end
			end
		end
	end
endmodule // mpic_mem_model

// [tb/mpic_input_ctrl_bench.sv]
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Bench
// ---------------------------------------------------------------
module mpic_input_ctrl_bench;
	typedef struct packed {logic [15:0] input_control_word; logic [15:0] output_control_word; logic [4:0] flg; logic [7:0] exp;} mpic_row_t;
	mpic_row_t rows [0:6];
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic rx_valid = 1'b0;
	logic [6:0] rx_port = 7'h00;
	logic [7:0] rx_char = 8'h00;
	logic [4:0] flg = 5'h00;
	logic rtc_event = 1'b0;
	logic stack_overflow = 1'b0;
	logic io_read_status = 1'b0;
	logic io_read_clear = 1'b0;
	logic stall = 1'b0;
	logic [14:0] echo_seen = 15'h0000;
	wire rx_ready, mem_req_r, mem_we_r, mem_ack, echo_valid_r, io_data_valid, host_irq;
	wire [14:0] mem_addr_r;
	wire [15:0] mem_wdata_r, mem_rdata, io_data;
	wire [6:0] echo_port_r;
	wire [7:0] echo_char_r;
	integer err_count = 0, checked = 0, i, n, k, a;
	localparam [14:0] BASE = 15'h0100;
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) if (echo_valid_r === 1'b1) echo_seen <= {echo_port_r, echo_char_r};
	mpic_input_ctrl dut (.core_clk(core_clk), .reset(reset), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_port(rx_port), .rx_char(rx_char), .rx_parity_err(flg[4]), .rx_overload(flg[3]), .rx_break(flg[2]),
		.rx_special(flg[1]), .rx_echo_blocked(flg[0]), .pcb_base(BASE), .mem_req_r(mem_req_r),
		.mem_we_r(mem_we_r), .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .echo_valid_r(echo_valid_r), .echo_port_r(echo_port_r),
		.echo_char_r(echo_char_r), .rtc_event(rtc_event), .stack_overflow(stack_overflow),
		.io_read_status(io_read_status), .io_read_clear(io_read_clear), .io_data(io_data),
		.io_data_valid(io_data_valid), .host_irq(host_irq));
	mpic_mem_model mem (.core_clk(core_clk), .reset(reset), .mem_req_r(mem_req_r), .mem_we_r(mem_we_r),
		.mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r), .stall(stall), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("checked=%0d err_count=%0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task bad_wait;
		err_count = err_count + 1;
		tally_and_finish;
	endtask
	task wait_word(input integer wa, input logic [15:0] e);
		n = 0;
		while (mem.ram[wa] !== e && n < 400) begin
			@(posedge core_clk);
			n = n + 1;
		end
		if (n == 400) bad_wait;
		check(mem.ram[wa], e);
	endtask
	task wait_irq(input logic e);
		n = 0;
		while (host_irq !== e && n < 400) begin
			@(posedge core_clk);
			n = n + 1;
		end
		check({15'h0000, host_irq}, {15'h0000, e});
	endtask
	task send(input logic [6:0] p, input logic [7:0] c, input logic [4:0] f);
		@(posedge core_clk) #1;
		rx_port = p;
		rx_char = c;
		flg = f;
		rx_valid = 1'b1;
		n = 0;
		@(posedge core_clk);
		while (rx_ready !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			n = n + 1;
		end
		if (n == 400) bad_wait;
		#1 rx_valid = 1'b0;
	endtask
	task rd(input logic clr, input logic [15:0] e);
		@(posedge core_clk) #1;
		io_read_clear = clr;
		io_read_status = ~clr;
		@(posedge core_clk) #1;
		io_read_clear = 1'b0;
		io_read_status = 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			n = n + 1;
		end while (io_data_valid !== 1'b1 && n < 8);
		if (n == 8) bad_wait;
		check(io_data, e);
	endtask
	initial begin
		rows[0] = '{16'h0000, 16'h0000, 5'h00, 8'h01};
		rows[1] = '{16'h0004, 16'h0000, 5'h00, 8'h05};
		rows[2] = '{16'h0002, 16'h0000, 5'h10, 8'h03};
		rows[3] = '{16'h0002, 16'h0000, 5'h08, 8'h03};
		rows[4] = '{16'h0002, 16'h0000, 5'h04, 8'h03};
		rows[5] = '{16'h000a, 16'h0000, 5'h02, 8'h0b};
		rows[6] = '{16'h0006, 16'h0000, 5'h01, 8'h47};
		repeat (8) @(posedge core_clk);
		#1 reset = 1'b0;
		check({13'h0000, rx_ready, host_irq, mem_req_r}, 16'h0004);
		$display("test reset done");
		for (i = 0; i < 7; i = i + 1) begin
			a = BASE + (i + 1) * 32;
			mem.ram[a] = rows[i].input_control_word;
			mem.ram[a + 1] = rows[i].output_control_word;
			send(i + 1, 8'h30 + i, rows[i].flg);
			wait_word(a, {8'h30 + i[7:0], rows[i].exp});
			wait_irq(1'b1);
			rd(1'b1, {5'h00, i[6:0] + 7'h01, 4'h4});
			wait_irq(1'b0);
			mem.ram[a] = 16'h0000;
			$display("test row %0d done", i);
		end
		a = BASE + 320;
		mem.ram[a] = 16'h0006;
		mem.ram[a + 1] = 16'h0100;
		mem.ram[a + 4] = 16'h0080;
		mem.ram[a + 6] = 16'h0081;
		send(7'd10, 8'ha5, 5'h10);
		wait_word(a + 4, 16'h0081);
		check({15'h0000, host_irq}, 16'h0000);
		send(7'd10, 8'h5a, 5'h00);
		wait_word(a + 4, 16'h0082);
		wait_irq(1'b1);
		check(mem.ram[64], 16'ha55a);
		check({8'h00, mem.ram[a][7:0]}, 16'h0007);
		check({1'b0, echo_seen}, 16'h0a5a);
		rd(1'b0, 16'h00a4);
		rd(1'b1, 16'h00a4);
		wait_irq(1'b0);
		$display("test buffer done");
		a = BASE + 96;
		mem.ram[a] = 16'h0001;
		@(posedge core_clk) #1;
		stall = 1'b1;
		rx_port = 7'd3;
		flg = 5'h00;
		rx_char = 8'h60;
		rx_valid = 1'b1;
		k = 0;
		for (n = 0; n < 40; n = n + 1) begin
			@(posedge core_clk);
			if (rx_ready !== 1'b1) break;
			k = k + 1;
			#1 rx_char = 8'h60 + k;
		end
		#1 rx_valid = 1'b0;
		check({15'h0000, k >= 16 && k < 40}, 16'h0001);
		stall = 1'b0;
		wait_word(a, {8'h5f + k[7:0], 8'h81});
		repeat (20) @(posedge core_clk);
		check({15'h0000, host_irq}, 16'h0000);
		$display("test overrun done");
		@(posedge core_clk) #1;
		rtc_event = 1'b1;
		stack_overflow = 1'b1;
		@(posedge core_clk) #1;
		rtc_event = 1'b0;
		stack_overflow = 1'b0;
		wait_irq(1'b1);
		rd(1'b1, 16'h0003);
		wait_irq(1'b0);
		$display("test events done");
		tally_and_finish;
	end
endmodule // mpic_input_ctrl_bench
